/* File: design/wwds_top.sv */
// window watchdog supervisor top
`timescale 1ns/1ps
module wwds_top #(
    parameter int unsigned T0 = wwds_pkg::T0_TICKS,
    parameter int unsigned T1 = wwds_pkg::T1_TICKS,
    parameter int unsigned T2 = wwds_pkg::T2_TICKS,
    parameter int unsigned T3 = wwds_pkg::T3_TICKS,
    parameter int unsigned T4 = wwds_pkg::T4_TICKS,
    parameter int unsigned T5 = wwds_pkg::T5_TICKS,
    parameter int unsigned T6 = wwds_pkg::T6_TICKS,
    parameter int unsigned TRIG_MIN = wwds_pkg::TRIG_MIN_CYC,
    parameter int unsigned TRIG_MAX = wwds_pkg::TRIG_MAX_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic power_good,
    input wire logic tick,
    input wire logic trigger_in,
    input wire logic long_mode,
    input wire logic supervisor_off_n,
    output logic mcu_reset_out,
    output wwds_pkg::wwds_state_t state
);
    import wwds_pkg::*;

    localparam int unsigned TMAX = 1 << TIMER_W;
    initial begin
        if (T0 < 1 || T1 < 1 || T2 < 1 || T3 < 1 || T4 < 1 || T5 < 1
            || T6 < 1 || T0 >= TMAX || T1 >= TMAX || T2 + T3 >= TMAX
            || T4 + T5 >= TMAX || T6 >= TMAX)
            $error("wwds_top: interval out of range");
    end

    // ==========================================================
    // reset release and input synchronisers
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    typedef struct packed {
        logic [1:0] pg;
        logic [1:0] tk;
        logic [1:0] md;
        logic [1:0] en;
        logic tk_prev;
        wwds_state_t fsm;
        logic [TIMER_W-1:0] timer;
        logic rst_out;
    } wwds_regs_t;

    wwds_regs_t st;
    wwds_regs_t next_st;

    logic trig_ok;
    logic trig_err;

    wwds_trigger #(
        .MIN_CYC(TRIG_MIN),
        .MAX_CYC(TRIG_MAX)
    ) u_trig (
        .clk(clk),
        .rst_n(rst_n),
        .trigger_in(trigger_in),
        .valid_trigger_pulse(trig_ok),
        .trigger_error(trig_err)
    );

    // ==========================================================
    // supervisor state machine
    logic tick_rise;
    logic mode_long;
    logic enabled;
    logic [TIMER_W-1:0] closed_len;
    logic [TIMER_W-1:0] window_len;
    assign tick_rise = st.tk[1] && !st.tk_prev;
    assign mode_long = st.md[1];
    assign enabled = st.en[1];
    assign closed_len = mode_long ? TIMER_W'(T4) : TIMER_W'(T2);
    assign window_len = mode_long ? TIMER_W'(T4 + T5) : TIMER_W'(T2 + T3);

    always_comb begin
        next_st = st;
        next_st.pg = {st.pg[0], power_good};
        next_st.tk = {st.tk[0], tick};
        next_st.md = {st.md[0], long_mode};
        next_st.en = {st.en[0], supervisor_off_n};
        next_st.tk_prev = st.tk[1];
        if (tick_rise)
            next_st.timer = st.timer + 1'b1;
        unique case (st.fsm)
            WWDS_POR: begin
                next_st.rst_out = 1'b0;
                if (!st.pg[1]) begin
                    next_st.timer = '0;
                end else if (st.timer >= TIMER_W'(T0)) begin
                    next_st.fsm = WWDS_SYNC;
                    next_st.timer = '0;
                    next_st.rst_out = 1'b1;
                end
            end
            WWDS_SYNC: begin
                if (trig_ok) begin
                    next_st.fsm = WWDS_CLOSED;
                    next_st.timer = '0;
                end else if (st.timer >= TIMER_W'(T1)) begin
                    next_st.fsm = WWDS_RESET;
                    next_st.timer = '0;
                    next_st.rst_out = 1'b0;
                end
            end
            WWDS_CLOSED: begin
                if (trig_ok) begin
                    next_st.fsm = WWDS_RESET;
                    next_st.timer = '0;
                    next_st.rst_out = 1'b0;
                end else if (st.timer >= closed_len) begin
                    next_st.fsm = WWDS_OPEN;
                end
            end
            WWDS_OPEN: begin
                if (trig_ok) begin
                    next_st.fsm = WWDS_CLOSED;
                    next_st.timer = '0;
                end else if (st.timer >= window_len) begin
                    next_st.fsm = WWDS_RESET;
                    next_st.timer = '0;
                    next_st.rst_out = 1'b0;
                end else if (st.timer < closed_len) begin
                    next_st.fsm = WWDS_CLOSED;
                end
            end
            WWDS_RESET: begin
                next_st.rst_out = 1'b0;
                if (trig_ok) begin
                    next_st.timer = '0;
                end else if (st.timer >= TIMER_W'(T6)) begin
                    next_st.fsm = WWDS_SYNC;
                    next_st.timer = '0;
                    next_st.rst_out = 1'b1;
                end
            end
            WWDS_OFF: begin
                next_st.rst_out = 1'b1;
                next_st.timer = '0;
                if (enabled)
                    next_st.fsm = WWDS_SYNC;
            end
            default: begin
                next_st.fsm = WWDS_POR;
                next_st.timer = '0;
                next_st.rst_out = 1'b0;
            end
        endcase
        // disable overrides supervision once powered up
        if (st.fsm != WWDS_POR && !enabled) begin
            next_st.fsm = WWDS_OFF;
            next_st.timer = '0;
            next_st.rst_out = 1'b1;
        end else if (st.fsm != WWDS_POR && trig_err) begin
            // hold reset, t6 only runs once the trigger is high again
            next_st.fsm = WWDS_RESET;
            next_st.timer = '0;
            next_st.rst_out = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{pg: 2'h0, tk: 2'h0, md: 2'h3, en: 2'h3, tk_prev: 1'b0,
                    fsm: WWDS_POR, timer: '0, rst_out: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign mcu_reset_out = st.rst_out;
    assign state = st.fsm;

    // ==========================================================
    // checks
    sequence seq_closed_trig;
        st.fsm == WWDS_CLOSED && trig_ok && enabled && !trig_err;
    endsequence

    chk_por_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_POR |-> !mcu_reset_out)
        else $error("reset output high during power-on");
    chk_start_release: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_POR && st.pg[1] && st.timer >= TIMER_W'(T0)
        |=> st.fsm == WWDS_SYNC && mcu_reset_out)
        else $error("start-up interval not ended");
    chk_sync_entry: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_SYNC && trig_ok && enabled && !trig_err
        |=> st.fsm == WWDS_CLOSED && st.timer == '0)
        else $error("sync trigger did not start window");
    chk_closed_trig: assert property (
        @(posedge clk) disable iff (!rst_n)
        seq_closed_trig |=> st.fsm == WWDS_RESET && !mcu_reset_out)
        else $error("closed window trigger did not reset");
    chk_open_trig: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_OPEN && trig_ok && enabled && !trig_err
        |=> st.fsm == WWDS_CLOSED && mcu_reset_out)
        else $error("open window trigger mishandled");
    chk_sync_timeout: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_SYNC && !trig_ok && enabled && !trig_err
        && st.timer >= TIMER_W'(T1) |=> st.fsm == WWDS_RESET)
        else $error("sync timeout missed");
    chk_window_timeout: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_OPEN && !trig_ok && enabled && !trig_err
        && st.timer >= window_len |=> st.fsm == WWDS_RESET)
        else $error("window timeout missed");
    chk_disable_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm != WWDS_POR && !enabled |=> st.fsm == WWDS_OFF
        && mcu_reset_out)
        else $error("disable not honoured");
    chk_error_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm != WWDS_POR && enabled && trig_err |=> !mcu_reset_out
        && st.fsm == WWDS_RESET && st.timer == '0)
        else $error("overlong trigger did not hold reset");
    chk_reset_restart: assert property (
        @(posedge clk) disable iff (!rst_n)
        st.fsm == WWDS_RESET && trig_ok && enabled && !trig_err
        |=> st.fsm == WWDS_RESET && st.timer == '0)
        else $error("reset timer not restarted");
endmodule : wwds_top

/* File: design/wwds_pkg.sv */
// package: constants for the window watchdog supervisor
package wwds_pkg;
    // default interval counts in tick periods
    localparam int unsigned T0_TICKS = 16;
    localparam int unsigned T1_TICKS = 32;
    localparam int unsigned T2_TICKS = 8;
    localparam int unsigned T3_TICKS = 8;
    localparam int unsigned T4_TICKS = 32;
    localparam int unsigned T5_TICKS = 32;
    localparam int unsigned T6_TICKS = 4;
    // trigger low time limits
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TRIG_MIN_US = 10;
    localparam int unsigned TRIG_MAX_MS = 5;
    localparam int unsigned TRIG_MIN_CYC =
        (TRIG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRIG_MAX_CYC =
        (TRIG_MAX_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;
    localparam int LOW_W = 20;

    typedef enum logic [2:0] {
        WWDS_POR = 3'b000,
        WWDS_SYNC = 3'b001,
        WWDS_CLOSED = 3'b010,
        WWDS_OPEN = 3'b011,
        WWDS_RESET = 3'b100,
        WWDS_OFF = 3'b101
    } wwds_state_t;
endpackage : wwds_pkg

/* File: design/wwds_trigger.sv */
// trigger input synchroniser and low pulse width qualifier
`timescale 1ns/1ps
module wwds_trigger #(
    parameter int unsigned MIN_CYC = wwds_pkg::TRIG_MIN_CYC,
    parameter int unsigned MAX_CYC = wwds_pkg::TRIG_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trigger_in,
    output logic valid_trigger_pulse,
    output logic trigger_error
);
    import wwds_pkg::*;

    initial begin
        if (MIN_CYC < 1 || MAX_CYC <= MIN_CYC || MAX_CYC + 1 >= (1 << LOW_W))
            $error("wwds_trigger: bad pulse limits");
    end

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic [LOW_W-1:0] low_cnt;
        logic valid;
    } wwds_trig_t;

    wwds_trig_t st;
    wwds_trig_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = trigger_in;
        next_st.s2 = st.s1;
        next_st.prev = st.s2;
        next_st.valid = 1'b0;
        if (!st.s2) begin
            if (st.low_cnt != LOW_W'(MAX_CYC + 1))
                next_st.low_cnt = st.low_cnt + 1'b1;
        end else begin
            next_st.low_cnt = '0;
        end
        // rising edge ends a low pulse of legal width
        if (st.s2 && !st.prev && st.low_cnt >= LOW_W'(MIN_CYC)
            && st.low_cnt <= LOW_W'(MAX_CYC))
            next_st.valid = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, low_cnt: '0,
                    valid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign valid_trigger_pulse = st.valid;
    assign trigger_error = !st.s2 && st.low_cnt > LOW_W'(MAX_CYC);
endmodule : wwds_trigger

/* File: sim/wwds_mcu_model.sv */
// microcontroller model issuing trigger pulses
`timescale 1ns/1ps
module wwds_mcu_model (
    input wire logic clk,
    input wire logic mcu_reset_out,
    output logic trigger_in
);
    // idle high, as the pin pull-up would leave it
    initial trigger_in = 1'b1;
    // released reset pulses seen by the controller
    int n_resets = 0;
    always @(posedge mcu_reset_out) n_resets++;
    // ========================================
    // low pulse of n cycles
    task automatic pulse(input int n);
        @(negedge clk);
        trigger_in = 1'b0;
        repeat (n) @(negedge clk);
        trigger_in = 1'b1;
    endtask : pulse
endmodule : wwds_mcu_model

/* File: sim/tb.sv */
// self-checking testbench for the window watchdog supervisor
`timescale 1ns/1ps
module tb;
    import wwds_pkg::*;
    localparam int P = 20;
    localparam int LIMIT = 20000;
    localparam int T0 = 4, T1 = 8, T2 = 4, T3 = 4, T4 = 10, T5 = 20, T6 = 3;
    logic clk, arst_n, power_good, long_mode, supervisor_off_n;
    logic tick = 1'b0;
    logic trigger_in, mcu_reset_out;
    wwds_state_t state;
    int num_errors = 0, n_checks = 0, tcnt = 0, cyc = 0, n;
    // ========================================
    // instances
    wwds_top #(.T0(T0), .T1(T1), .T2(T2), .T3(T3), .T4(T4), .T5(T5),
        .T6(T6), .TRIG_MIN(10), .TRIG_MAX(200)) u_wwds_top (
        .clk(clk),
        .arst_n(arst_n),
        .power_good(power_good),
        .tick(tick),
        .trigger_in(trigger_in),
        .long_mode(long_mode),
        .supervisor_off_n(supervisor_off_n),
        .mcu_reset_out(mcu_reset_out),
        .state(state)
    );
    wwds_mcu_model u_wwds_mcu_model (
        .clk(clk),
        .mcu_reset_out(mcu_reset_out),
        .trigger_in(trigger_in)
    );
    // ========================================
    // clock, tick and watchdog on the run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        tcnt <= (tcnt == P - 1) ? 0 : tcnt + 1;
        tick <= (tcnt < 2);
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            end_of_test();
        end
    end
    // ========================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_st(input wwds_state_t s, input int lim);
        n = 0;
        while (state !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(16'(state), 16'(s));
    endtask : wait_st
    task automatic trig_then(input wwds_state_t s);
        u_wwds_mcu_model.pulse(20);
        repeat (8) @(negedge clk);
        chk(16'(state), 16'(s));
    endtask : trig_then
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // ========================================
    // scenarios
    task automatic t_power();
        repeat (20) @(negedge clk);
        chk(16'(mcu_reset_out), 16'h0000);
        chk(16'(state), 16'(WWDS_POR));
        power_good = 1'b1;
        wait_st(WWDS_SYNC, (T0 + 3) * P);
        chk(16'(n >= (T0 - 1) * P), 16'h0001);
        chk(16'(mcu_reset_out), 16'h0001);
    endtask : t_power
    task automatic t_sync_timeout();
        u_wwds_mcu_model.pulse(3);
        repeat (8) @(negedge clk);
        chk(16'(state), 16'(WWDS_SYNC));
        wait_st(WWDS_RESET, (T1 + 3) * P);
        chk(16'(n >= (T1 - 2) * P), 16'h0001);
        chk(16'(mcu_reset_out), 16'h0000);
        wait_st(WWDS_SYNC, (T6 + 3) * P);
    endtask : t_sync_timeout
    task automatic t_closed_trig(input logic m);
        long_mode = m;
        trig_then(WWDS_CLOSED);
        trig_then(WWDS_RESET);
        chk(16'(mcu_reset_out), 16'h0000);
        wait_st(WWDS_SYNC, (T6 + 3) * P);
    endtask : t_closed_trig
    task automatic t_reset_restart();
        trig_then(WWDS_CLOSED);
        trig_then(WWDS_RESET);
        u_wwds_mcu_model.pulse(20);
        chk(16'(mcu_reset_out), 16'h0000);
        wait_st(WWDS_SYNC, (T6 + 3) * P);
        chk(16'(n >= (T6 - 1) * P), 16'h0001);
    endtask : t_reset_restart
    task automatic t_window();
        long_mode = 1'b1;
        trig_then(WWDS_CLOSED);
        long_mode = 1'b0;
        wait_st(WWDS_OPEN, (T2 + 3) * P);
        trig_then(WWDS_CLOSED);
        chk(16'(mcu_reset_out), 16'h0001);
        wait_st(WWDS_OPEN, (T2 + 3) * P);
        wait_st(WWDS_RESET, (T3 + 3) * P);
        chk(16'(n >= (T3 - 1) * P), 16'h0001);
        wait_st(WWDS_SYNC, (T6 + 3) * P);
    endtask : t_window
    task automatic t_disable();
        supervisor_off_n = 1'b0;
        repeat (10) @(negedge clk);
        chk(16'(state), 16'(WWDS_OFF));
        repeat ((T1 + 2) * P) @(negedge clk);
        chk(16'(state), 16'(WWDS_OFF));
        chk(16'(mcu_reset_out), 16'h0001);
        supervisor_off_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(16'(state), 16'(WWDS_SYNC));
    endtask : t_disable
    task automatic t_error();
        long_mode = 1'b1;
        trig_then(WWDS_CLOSED);
        fork
            u_wwds_mcu_model.pulse(300);
            begin
                repeat (250) @(negedge clk);
                chk(16'(mcu_reset_out), 16'h0000);
            end
        join
        repeat (8) @(negedge clk);
        chk(16'(state), 16'(WWDS_RESET));
        wait_st(WWDS_SYNC, (T6 + 3) * P);
    endtask : t_error
    // ========================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        power_good = 1'b0;
        long_mode = 1'b1;
        supervisor_off_n = 1'b1;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        t_power();
        t_sync_timeout();
        t_closed_trig(1'b0);
        t_closed_trig(1'b1);
        t_reset_restart();
        t_window();
        t_disable();
        t_error();
        chk(16'(u_wwds_mcu_model.n_resets), 16'h0007);
        end_of_test();
    end
endmodule : tb
